// file: fbpi_defines.svh
/*
 * constants for the four-pin port block: register byte offsets, field
 * positions, writable masks, reset values and bus answers.
 * assumes it is included by its bare name after the file header comment.
 */
`ifndef FBPI_DEFINES_SVH
`define FBPI_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define FBPI_ADDR_W        8
`define FBPI_OFF_DATA      8'h00
`define FBPI_OFF_OUT_EN    8'h04
`define FBPI_OFF_FUNC_SEL  8'h08
`define FBPI_OFF_OPEN_DR   8'h28
`define FBPI_OFF_PULLUP    8'h2C
`define FBPI_OFF_IN_EN     8'h38

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define FBPI_PINS          4
`define FBPI_MASK_DATA     4'hF
`define FBPI_MASK_OUT_EN   4'hF
`define FBPI_MASK_FUNC_SEL 4'hE
`define FBPI_MASK_OPEN_DR  4'hD
`define FBPI_MASK_PULLUP   4'h1
`define FBPI_MASK_IN_EN    4'hF
`define FBPI_RST_PINS      4'h0
`define FBPI_BIT_CEC       1
`define FBPI_BIT_INT_E     2
`define FBPI_BIT_INT_F     3
`define FBPI_BIT_BOOT      0

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define FBPI_RESP_OKAY     2'h0
`define FBPI_RESP_SLVERR   2'h2

`endif

// file: fbpi_pad_model.sv
/*
 * pad model for the four-pin port: resolves each pad from the port's own
 * driver, an outside driver set by the bench and the pin 0 pull-up.
 * assumes the bench changes ext_en and ext_val just after clock edges.
 */
`timescale 1ns/10ps
`default_nettype none

module fbpi_pad_model
   import fbpi_pkg::*;
(
   input  wire logic       aclk,
   input  wire fbpi_pins_t pin_out,
   input  wire fbpi_pins_t pin_oe,
   input  wire logic       pin0_pullup,
   input  wire fbpi_pins_t ext_en,
   input  wire fbpi_pins_t ext_val,
   output var  fbpi_pins_t pin_in
);
   // ----------------------------------------------------------------------
   // pad resolution
   // ----------------------------------------------------------------------
   // an undriven pad keeps changing, so a floating read never looks settled
   fbpi_pins_t wander_q = 4'h5;

   always @(posedge aclk) begin
      wander_q <= ~wander_q;
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_val[i];
         else if (i == 0 && pin0_pullup)
            pin_in[i] = 1'b1;
         else
            pin_in[i] = wander_q[i];
      end
   end
endmodule // fbpi_pad_model

`default_nettype wire

// file: fbpi_pkg.sv
/*
 * types shared by the four-pin port block.
 * assumes fbpi_defines.svh is on the include path.
 */
`include "fbpi_defines.svh"

package fbpi_pkg;
   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef logic [`FBPI_PINS-1:0]   fbpi_pins_t;
   typedef logic [`FBPI_ADDR_W-1:0] fbpi_addr_t;
   typedef logic [1:0]              fbpi_resp_t;
endpackage

// file: fbpi_port.sv
/*
 * four-pin general-purpose port with output enable, input enable,
 * open-drain select, alternate-function select, pin 0 pull-up and the
 * pin 0 boot strap, reached over an AXI4-Lite slave.
 * assumes one clock, pads resolved outside from pin_out and pin_oe, and a
 * master that keeps at most one write and one read outstanding.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fbpi_defines.svh"

module fbpi_port
   import fbpi_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [3:0]  pin_in,
   output logic [3:0]       pin_out,
   output logic [3:0]       pin_oe,
   output logic             pin0_pullup,
   input  wire logic        deep_stop,
   input  wire logic        cec_tx_low,
   output logic             cec_rx,
   output logic             external_interrupt_e,
   output logic             external_interrupt_f,
   output logic             boot_from_flash
);

   // ----------------------------------------------------------------------
   // port registers
   // ----------------------------------------------------------------------
   fbpi_pins_t pin_data_q,          pin_data_d;
   fbpi_pins_t output_enable_q,     output_enable_d;
   fbpi_pins_t function_select_q,   function_select_d;
   fbpi_pins_t open_drain_select_q, open_drain_select_d;
   fbpi_pins_t pullup_control_q,    pullup_control_d;
   fbpi_pins_t input_enable_q,      input_enable_d;

   // ----------------------------------------------------------------------
   // bus slave state
   // ----------------------------------------------------------------------
   logic        aw_held_q,  aw_held_d;
   logic        w_held_q,   w_held_d;
   fbpi_addr_t  wr_addr_q,  wr_addr_d;
   logic [31:0] wr_data_q,  wr_data_d;
   logic [3:0]  wr_strb_q,  wr_strb_d;
   logic        bvalid_q,   bvalid_d;
   fbpi_resp_t  bresp_q,    bresp_d;
   logic        rvalid_q,   rvalid_d;
   fbpi_resp_t  rresp_q,    rresp_d;
   logic [31:0] rdata_q,    rdata_d;
   fbpi_addr_t  rd_addr_q,  rd_addr_d;

   // ----------------------------------------------------------------------
   // boot strap state and bus helper signals
   // ----------------------------------------------------------------------
   logic        in_reset_q, in_reset_d;
   logic        boot_q,     boot_d;
   logic        wr_fire;
   logic        wr_lane0;
   fbpi_addr_t  wr_word;
   fbpi_addr_t  rd_word;
   fbpi_pins_t  data_view;
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   // the write fires once both halves have been held, never on the fly
   assign wr_fire  = aw_held_q && w_held_q && !bvalid_q;
   assign wr_lane0 = wr_strb_q[0];
   assign wr_word  = {wr_addr_q[7:2], 2'b00};
   assign rd_word  = {s_axi_araddr[7:2], 2'b00};
   // an enabled input reads the pad, otherwise the output latch
   assign data_view = (input_enable_q & pin_in) | (~input_enable_q & pin_data_q);

   // ----------------------------------------------------------------------
   // bus slave next state
   // ----------------------------------------------------------------------
   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d  = w_held_q;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      wr_strb_d = wr_strb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      rd_addr_d = rd_addr_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_d = 1'b1;
         wr_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_d  = 1'b1;
         wr_data_d = s_axi_wdata;
         wr_strb_d = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         unique case (wr_word)
            `FBPI_OFF_DATA, `FBPI_OFF_OUT_EN, `FBPI_OFF_FUNC_SEL,
            `FBPI_OFF_OPEN_DR, `FBPI_OFF_PULLUP, `FBPI_OFF_IN_EN: bresp_d = `FBPI_RESP_OKAY;
            default: bresp_d = `FBPI_RESP_SLVERR;
         endcase
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d  = 1'b1;
         rd_addr_d = rd_word;
         rresp_d   = `FBPI_RESP_OKAY;
         rdata_d   = 32'h0000_0000;
         unique case (rd_word)
            `FBPI_OFF_DATA:    rdata_d[3:0] = data_view & `FBPI_MASK_DATA;
            `FBPI_OFF_OUT_EN:  rdata_d[3:0] = output_enable_q & `FBPI_MASK_OUT_EN;
            `FBPI_OFF_FUNC_SEL: begin
               rdata_d[3:0] = function_select_q & `FBPI_MASK_FUNC_SEL;
            end
            `FBPI_OFF_OPEN_DR: begin
               rdata_d[3:0] = open_drain_select_q & `FBPI_MASK_OPEN_DR;
            end
            `FBPI_OFF_PULLUP:  rdata_d[3:0] = pullup_control_q & `FBPI_MASK_PULLUP;
            `FBPI_OFF_IN_EN:   rdata_d[3:0] = input_enable_q & `FBPI_MASK_IN_EN;
            default:           rresp_d = `FBPI_RESP_SLVERR;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 32'h0000_0000;
         wr_strb_q <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `FBPI_RESP_OKAY;
         rvalid_q  <= 1'b0;
         rresp_q   <= `FBPI_RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
         rd_addr_q <= 8'h00;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q  <= w_held_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         wr_strb_q <= wr_strb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         rd_addr_q <= rd_addr_d;
      end
   end

   // ----------------------------------------------------------------------
   // port register next state
   // ----------------------------------------------------------------------
   // all fields live in byte lane 0; reserved positions are masked off
   always_comb begin
      pin_data_d          = pin_data_q;
      output_enable_d     = output_enable_q;
      function_select_d   = function_select_q;
      open_drain_select_d = open_drain_select_q;
      pullup_control_d    = pullup_control_q;
      input_enable_d      = input_enable_q;
      if (wr_fire && wr_lane0) begin
         unique case (wr_word)
            `FBPI_OFF_DATA: pin_data_d = wr_data_q[3:0] & `FBPI_MASK_DATA;
            `FBPI_OFF_OUT_EN: output_enable_d = wr_data_q[3:0] & `FBPI_MASK_OUT_EN;
            `FBPI_OFF_FUNC_SEL: begin
               function_select_d = wr_data_q[3:0] & `FBPI_MASK_FUNC_SEL;
            end
            `FBPI_OFF_OPEN_DR: begin
               open_drain_select_d = wr_data_q[3:0] & `FBPI_MASK_OPEN_DR;
            end
            `FBPI_OFF_PULLUP: begin
               pullup_control_d = wr_data_q[3:0] & `FBPI_MASK_PULLUP;
            end
            `FBPI_OFF_IN_EN: input_enable_d = wr_data_q[3:0] & `FBPI_MASK_IN_EN;
            default: pin_data_d = pin_data_q;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_data_q          <= `FBPI_RST_PINS;
         output_enable_q     <= `FBPI_RST_PINS;
         function_select_q   <= `FBPI_RST_PINS;
         open_drain_select_q <= `FBPI_RST_PINS;
         pullup_control_q    <= `FBPI_RST_PINS;
         input_enable_q      <= `FBPI_RST_PINS;
      end else begin
         pin_data_q          <= pin_data_d;
         output_enable_q     <= output_enable_d;
         function_select_q   <= function_select_d;
         open_drain_select_q <= open_drain_select_d;
         pullup_control_q    <= pullup_control_d;
         input_enable_q      <= input_enable_d;
      end
   end

   // ----------------------------------------------------------------------
   // boot strap capture
   // ----------------------------------------------------------------------
   // reset is synchronous, so the strap is caught on the first edge after release
   always_comb begin
      in_reset_d = 1'b0;
      boot_d     = boot_q;
      if (in_reset_q)
         boot_d = pin_in[`FBPI_BIT_BOOT];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_reset_q <= 1'b1;
         boot_q     <= 1'b0;
      end else begin
         in_reset_q <= in_reset_d;
         boot_q     <= boot_d;
      end
   end

   assign boot_from_flash = boot_q;
   // pull-up stays on through the sampling edge
   assign pin0_pullup = !aresetn || in_reset_q || pullup_control_q[0];

   // ----------------------------------------------------------------------
   // pad drive and alternate functions
   // ----------------------------------------------------------------------
   // pin 1 is an n-channel pad: it only ever pulls low
   genvar gi;
   generate
      for (gi = 0; gi < `FBPI_PINS; gi = gi + 1) begin : g_pad
         logic src;
         logic odrain;
         logic out_ok;
         if (gi == `FBPI_BIT_CEC) begin : g_cec
            assign src    = function_select_q[gi] ? !cec_tx_low : pin_data_q[gi];
            assign odrain = 1'b1;
            assign out_ok = output_enable_q[gi];
         end else if (gi == `FBPI_BIT_BOOT) begin : g_boot
            assign src    = pin_data_q[gi];
            assign odrain = open_drain_select_q[gi];
            assign out_ok = output_enable_q[gi] && !in_reset_q;
         end else begin : g_int
            // an interrupt pin routed away from the port drives nothing
            assign src    = pin_data_q[gi];
            assign odrain = open_drain_select_q[gi];
            assign out_ok = output_enable_q[gi] && !function_select_q[gi];
         end
         assign pin_out[gi] = odrain ? 1'b0 : src;
         assign pin_oe[gi]  = out_ok && (!odrain || !src);
      end
   endgenerate

   assign cec_rx = pin_in[`FBPI_BIT_CEC] && input_enable_q[`FBPI_BIT_CEC]
                   && function_select_q[`FBPI_BIT_CEC];
   // interrupt inputs ignore the function select; software must disable unused ones
   assign external_interrupt_e = pin_in[`FBPI_BIT_INT_E] && input_enable_q[`FBPI_BIT_INT_E]
                                 && !deep_stop;
   assign external_interrupt_f = pin_in[`FBPI_BIT_INT_F] && input_enable_q[`FBPI_BIT_INT_F]
                                 && !deep_stop;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   chk_oe_reset_clear: assert property (@(posedge aclk)
      !aresetn |=> (pin_oe == 4'h0) && (output_enable_q == 4'h0))
      else $error("output drivers not off after reset");
   chk_oe_gated_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      (pin_oe & ~output_enable_q) == 4'h0)
      else $error("pin driven without its output enable");
   chk_open_drain_low: assert property (@(posedge aclk) disable iff (!aresetn)
      (pin_oe[0] && open_drain_select_q[0]) |-> (pin_out[0] == 1'b0))
      else $error("open-drain pin driven high");
   chk_int_f_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      external_interrupt_f == (pin_in[3] && input_enable_q[3] && !deep_stop))
      else $error("interrupt f does not follow enabled pin");
   // once taken the strap must hold; the pad itself may wander afterwards
   chk_boot_sample: assert property (@(posedge aclk) disable iff (!aresetn)
      (aresetn && in_reset_q) |=> (boot_from_flash == $past(pin_in[0]))
         ##1 $stable(boot_from_flash))
      else $error("boot strap not taken at reset release");
   chk_pullup_reset: assert property (@(posedge aclk)
      !aresetn |-> pin0_pullup ##1 pin0_pullup)
      else $error("pin 0 pull-up off around reset");
   chk_reserved_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata[31:4] == 28'h000_0000))
      else $error("reserved read bits not zero");
   chk_data_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_lane0 && wr_word == `FBPI_OFF_DATA) |=>
         (pin_data_q == wr_data_q[3:0]) && s_axi_bvalid && (s_axi_bresp == `FBPI_RESP_OKAY))
      else $error("data register write lost");
   chk_fsel_bit0: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && rd_addr_q == `FBPI_OFF_FUNC_SEL) |-> (s_axi_rdata[0] == 1'b0))
      else $error("function select bit 0 reads nonzero");
   chk_pullup_field: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && rd_addr_q == `FBPI_OFF_PULLUP) |-> (s_axi_rdata[31:1] == 31'h0000_0000))
      else $error("pull-up upper bits read nonzero");
   chk_ie_reset: assert property (@(posedge aclk)
      !aresetn |=> (input_enable_q == 4'h0) && !external_interrupt_e && !cec_rx)
      else $error("input enables not cleared by reset");

endmodule // fbpi_port

`default_nettype wire

// file: fbpi_port_bench.sv
/*
 * self-checking bench for the four-pin port: register access over
 * AXI4-Lite, pad drive, interrupt and cec routing, boot strap.
 * assumes fbpi_defines.svh on the include path and the pad model beside.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fbpi_defines.svh"

module fbpi_port_bench
   import fbpi_pkg::*;
;
   logic        aclk;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic        deep_stop = 1'b0;
   logic        cec_tx_low = 1'b0;
   fbpi_addr_t  awaddr = 8'h00;
   fbpi_addr_t  araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'h0;
   fbpi_pins_t  ext_en = 4'h0;
   fbpi_pins_t  ext_val = 4'h0;
   logic [31:0] rdata;
   logic        awready, wready, bvalid, arready, rvalid, pin0_pullup;
   logic        cec_rx, int_e, int_f, boot;
   fbpi_resp_t  bresp, rresp;
   fbpi_pins_t  pin_in, pin_out, pin_oe;
   int          n_mismatch = 0;
   int          n_checks = 0;
   fbpi_addr_t  offs [6] = '{`FBPI_OFF_DATA, `FBPI_OFF_OUT_EN, `FBPI_OFF_FUNC_SEL,
                             `FBPI_OFF_OPEN_DR, `FBPI_OFF_PULLUP, `FBPI_OFF_IN_EN};
   logic [31:0] wmask [6] = '{32'h0000_000F, 32'h0000_000F, 32'h0000_000E,
                              32'h0000_000D, 32'h0000_0001, 32'h0000_000F};

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   fbpi_port i_fbpi_port (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin0_pullup(pin0_pullup), .deep_stop(deep_stop), .cec_tx_low(cec_tx_low),
      .cec_rx(cec_rx), .external_interrupt_e(int_e),
      .external_interrupt_f(int_f), .boot_from_flash(boot)
   );

   fbpi_pad_model i_fbpi_pad_model (
      .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin0_pullup(pin0_pullup),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
   );

   // ----------------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------------
   task automatic print_verdict;
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang;
      n_mismatch++;
      $display("ERROR %0t: bus gave no answer", $time);
      print_verdict();
   endtask

   // bready and rready stay high, so the answer edge is the bvalid/rvalid edge
   task automatic wr(input fbpi_addr_t a, input logic [31:0] d, input logic [3:0] s,
                     output fbpi_resp_t r);
      int n;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      if (n == 20) hang();
   endtask

   task automatic rd(input fbpi_addr_t a, output logic [31:0] d, output fbpi_resp_t r);
      int n;
      araddr  <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      if (n == 20) hang();
   endtask

   task automatic wchk(input fbpi_addr_t a, input logic [31:0] d);
      fbpi_resp_t r;
      wr(a, d, 4'hF, r);
      check(r, `FBPI_RESP_OKAY);
   endtask

   task automatic rchk(input fbpi_addr_t a, input logic [31:0] e);
      logic [31:0] d;
      fbpi_resp_t  r;
      rd(a, d, r);
      check(d, e);
      check(r, `FBPI_RESP_OKAY);
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      logic [31:0] d;
      fbpi_resp_t  r;
      repeat (10) @(posedge aclk);
      check(pin0_pullup, 1);
      check(pin_oe, 0);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      check(boot, 1);
      for (int i = 0; i < 6; i++) rchk(offs[i], 0);
      for (int i = 0; i < 6; i++) begin
         wchk(offs[i], 32'hFFFF_FFFF);
         rchk(offs[i], wmask[i]);
      end
      check(pin0_pullup, 1);
      for (int i = 0; i < 6; i++) wchk(offs[i], 0);
      check(pin0_pullup, 0);
      // a write with byte 0 not strobed leaves the fields alone
      wr(`FBPI_OFF_OUT_EN, 32'h0000_000F, 4'h0, r);
      rchk(`FBPI_OFF_OUT_EN, 0);
      wr(8'h10, 32'hFFFF_FFFF, 4'hF, r);
      check(r, `FBPI_RESP_SLVERR);
      rd(8'h10, d, r);
      check(d, 0);
      check(r, `FBPI_RESP_SLVERR);
      wchk(`FBPI_OFF_DATA, 32'h0000_0005);
      wchk(`FBPI_OFF_OUT_EN, 32'h0000_000F);
      check(pin_oe, 4'hF);
      check(pin_out, 4'h5);
      rchk(`FBPI_OFF_DATA, 32'h0000_0005);
      wchk(`FBPI_OFF_OPEN_DR, 32'h0000_000D);
      check(pin_oe, 4'hA);
      check(pin_out, 4'h0);
      wchk(`FBPI_OFF_OUT_EN, 0);
      wchk(`FBPI_OFF_OPEN_DR, 0);
      check(pin_oe, 4'h0);
      ext_en  <= 4'hF;
      ext_val <= 4'hE;
      wchk(`FBPI_OFF_IN_EN, 32'h0000_000F);
      rchk(`FBPI_OFF_DATA, 32'h0000_000E);
      check(int_e, 1);
      check(int_f, 1);
      check(cec_rx, 0);
      deep_stop <= 1'b1;
      @(posedge aclk);
      check(int_e, 0);
      check(int_f, 0);
      deep_stop <= 1'b0;
      wchk(`FBPI_OFF_FUNC_SEL, 32'h0000_000E);
      check(cec_rx, 1);
      check(int_e, 1);
      check(int_f, 1);
      // pin 1 follows the cec transmitter, pins 2 and 3 stay off the pad
      wchk(`FBPI_OFF_OUT_EN, 32'h0000_000F);
      check(pin_oe, 4'h1);
      cec_tx_low <= 1'b1;
      @(posedge aclk);
      check(pin_oe, 4'h3);
      check(pin_out[1], 0);
      cec_tx_low <= 1'b0;
      wchk(`FBPI_OFF_OUT_EN, 0);
      wchk(`FBPI_OFF_IN_EN, 0);
      check(int_e, 0);
      check(cec_rx, 0);
      // second reset with the strap pulled low from outside
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      check(boot, 0);
      rchk(`FBPI_OFF_FUNC_SEL, 0);
      print_verdict();
   end
endmodule // fbpi_port_bench

`default_nettype wire
